// [hdl/pbs_pkg.sv]
// package: constants and types for power button and supply control
package pbs_pkg;
   // ------------------------------------------------------------
   // Behaviour
   // [R1] sleep button held four seconds, outside soft-off, fires an override event
   // [R2] override drives main supply enable high and sets the override flag
   // [R3] buttons are seen only after about 16 ms of stable level
   // [R4] supply valid rise is qualified after one to two rtc ticks
   // [R5] main plane reset is held while qualified supply valid is low
   // [R6] supply logic keeps supply valid low 50 ms after the plane is valid
   // [R7] main supply enable asserted in full-on, idle and powered-on-suspend
   // [R8] ram supply enable low in suspend-to-disk and soft-off, else high
   // [R9] ring indicate sets its flag and can interrupt or wake
   // [R10] debounced sleep button sets its flag and wakes a sleep state
   // [R11] thermal warning enables throttling at the set ratio when enabled
   // [R12] suspend output follows its control bit
   // [R13] sleep and ring pins can become general purpose pins
   // [R14] management bus pins can become general purpose pins, else open drain
   // [R15] debounced power button sets its flag and wakes a sleep state
   // [R16] after reset main enable is low, ram enable and suspend high
   // [R17] debounce and hold timers count rtc ticks, cleared on level change
   // ------------------------------------------------------------

   // clock and timing
   localparam int CLK_HZ        = 40_000_000;
   localparam int RTC_HZ        = 32_768;
   localparam int RTC_DIV       = CLK_HZ / RTC_HZ;
   localparam int DIV_W         = 11;
   localparam int DEBOUNCE_MS   = 16;
   localparam int DB_W          = 10;
   localparam int DB_TICKS      = DEBOUNCE_MS * RTC_HZ / 1000;
   localparam int OVERRIDE_S    = 4;
   localparam int HOLD_W        = 18;
   localparam int OVR_TICKS     = OVERRIDE_S * RTC_HZ;

   // register offsets
   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] STAT_OFS  = 8'h04;
   localparam logic [7:0] MASK_OFS  = 8'h08;
   localparam logic [7:0] LEVEL_OFS = 8'h0c;

   // event bit positions in status and mask
   localparam int EVT_W     = 5;
   localparam int EV_POWER  = 0;
   localparam int EV_SLEEP  = 1;
   localparam int EV_OVR    = 2;
   localparam int EV_RING   = 3;
   localparam int EV_THERMAL_WARNING_N  = 4;

   // pin select bit positions in the control word
   localparam int SEL_SLEEP = 0;
   localparam int SEL_RING  = 1;
   localparam int SEL_MCLK  = 2;
   localparam int SEL_MDATA = 3;

   // synchroniser lanes
   localparam int SYNC_W    = 7;
   localparam int SY_PWR    = 6;
   localparam int SY_SLP    = 5;
   localparam int SY_RING   = 4;
   localparam int SY_THERMAL_WARNING_N  = 3;
   localparam int SY_PG     = 2;
   localparam int SY_MCLK   = 1;
   localparam int SY_MDATA  = 0;
   // idle pin levels: buttons released, supply invalid, bus lines pulled up
   // starting the synchroniser here keeps the edge detectors from seeing a false press after reset
   localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h7b;

   // system power states
   typedef enum logic [2:0] {
      full_on_state        = 3'h0,
      cpu_idle_level_two   = 3'h1,
      cpu_idle_level_three = 3'h2,
      powered_on_suspend   = 3'h3,
      suspend_to_ram_state = 3'h4,
      suspend_to_disk_state= 3'h5,
      soft_off_state       = 3'h6
   } pbs_pstate_e;

   // control register layout
   typedef struct packed {
      logic [11:0] zero;
      logic [3:0]  gpio_oe;
      logic [3:0]  gpio_out;
      logic [3:0]  pin_select;
      logic [2:0]  throttle_duty_ratio;
      logic        throttle_on_heat_enable;
      logic        suspend_on;
      pbs_pstate_e pstate;
   } pbs_ctrl_s;

   localparam logic [31:0]      CTRL_RESET = 32'h0000_0000;
   localparam logic [EVT_W-1:0] STAT_RESET = 5'h00;
   localparam logic [EVT_W-1:0] MASK_RESET = 5'h00;

endpackage

// [hdl/pbs_debounce.sv]
// module: button debounce filter counting rtc ticks
`timescale 1ns/100ps
module pbs_debounce #(
   parameter logic [pbs_pkg::DB_W-1:0] TICKS = pbs_pkg::DB_W'(pbs_pkg::DB_TICKS)
) (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic tick_in,
   input  wire logic raw_in,
   output logic      stable_out
);
   import pbs_pkg::*;

   typedef struct packed {
      logic [DB_W-1:0] cnt;
      logic            stable;
   } pbs_db_s;

   pbs_db_s state_reg;
   pbs_db_s state_next;

   // -----------------------------------------
   // filter
   // -----------------------------------------
   // any return to the held level restarts the wait, so bounce never leaks
   always_comb begin
      state_next = state_reg;
      if (raw_in == state_reg.stable) begin
         state_next.cnt = '0; // R17
      end else if (tick_in) begin
         if (state_reg.cnt == TICKS - 1'b1) begin
            state_next.stable = raw_in; // R3
            state_next.cnt    = '0;
         end else begin
            state_next.cnt = state_reg.cnt + 1'b1;
         end
      end
   end

   // register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign stable_out = state_reg.stable;

   db_on_tick_a: assert property (@(posedge clk_in) disable iff (rst_in) // R3
      $changed(stable_out) |-> $past(tick_in) && $past(raw_in) == stable_out)
      else $error("debounced level changed without a tick");
endmodule

// [hdl/pbs_ctrl.sv]
// module: power button and supply control with apb registers
`timescale 1ns/100ps
module pbs_ctrl #(
   parameter logic [pbs_pkg::DB_W-1:0]   DEBOUNCE_TICKS = pbs_pkg::DB_W'(pbs_pkg::DB_TICKS),
   parameter logic [pbs_pkg::HOLD_W-1:0] OVERRIDE_TICKS = pbs_pkg::HOLD_W'(pbs_pkg::OVR_TICKS)
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic             irq_out,
   input  wire logic        power_button_n_in,
   input  wire logic        sleep_button_n_in,
   output logic             sleep_button_n_out,
   output logic             sleep_button_n_oe_out,
   input  wire logic        ring_indicate_n_in,
   output logic             ring_indicate_n_out,
   output logic             ring_indicate_n_oe_out,
   input  wire logic        thermal_warning_n_in,
   input  wire logic        supply_valid_in,
   input  wire logic        mgmt_bus_clock_in,
   output logic             mgmt_bus_clock_out,
   output logic             mgmt_bus_clock_oe_out,
   input  wire logic        mgmt_bus_data_in,
   output logic             mgmt_bus_data_out,
   output logic             mgmt_bus_data_oe_out,
   input  wire logic        mgmt_clock_low_in,
   input  wire logic        mgmt_data_low_in,
   output logic             main_supply_enable_n_out,
   output logic             ram_supply_enable_out,
   output logic             suspend_n_out,
   output logic             plane_reset_out,
   output logic             throttle_active_out,
   output logic [2:0]       throttle_duty_ratio_out
);
   import pbs_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic [DIV_W-1:0]  div;
      logic              tick;
      logic              pg_seen;
      logic              pg_qual;
      logic [HOLD_W-1:0] hold;
      logic              ovr_done;
      logic              ovr_fire;
      logic              pwr_d;
      logic              slp_d;
      logic              ring_d;
      logic              thermal_warning_n_d;
      pbs_ctrl_s         ctrl;
      logic [EVT_W-1:0]  stat;
      logic [EVT_W-1:0]  mask;
      logic [31:0]       rdata;
      logic              ready;
      logic              slverr;
      logic              irq;
      logic              main_n;
      logic              ram_en;
      logic              susp_n;
      logic              plane_rst;
      logic              thr;
      logic [2:0]        ratio;
      logic [5:0]        pin_o;
      logic [5:0]        pin_oe;
   } pbs_state_s;

   pbs_state_s state_reg;
   pbs_state_s state_next;
   logic       pwr_db;
   logic       slp_db;

   // ------------------------------------------------------------
   // decoding helpers
   // ------------------------------------------------------------
   // main planes are off while suspended to ram or disk, or soft off
   function automatic logic main_off(input pbs_pstate_e p);
      unique case (p)
         suspend_to_ram_state, suspend_to_disk_state, soft_off_state: main_off = 1'b1;
         default: main_off = 1'b0;
      endcase
   endfunction

   function automatic logic ram_off(input pbs_pstate_e p);
      unique case (p)
         suspend_to_disk_state, soft_off_state: ram_off = 1'b1;
         default: ram_off = 1'b0;
      endcase
   endfunction

   function automatic logic asleep(input pbs_pstate_e p);
      unique case (p)
         powered_on_suspend, suspend_to_ram_state, suspend_to_disk_state: asleep = 1'b1;
         default: asleep = 1'b0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // button filters
   // ------------------------------------------------------------
   // sleep pin given over to general use reads as released
   pbs_debounce #(.TICKS(DEBOUNCE_TICKS)) u_pwr_db (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .tick_in    (state_reg.tick),
      .raw_in     (~state_reg.sync2[SY_PWR]),
      .stable_out (pwr_db)
   );

   pbs_debounce #(.TICKS(DEBOUNCE_TICKS)) u_slp_db (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .tick_in    (state_reg.tick),
      .raw_in     (~state_reg.sync2[SY_SLP] & ~state_reg.ctrl.pin_select[SEL_SLEEP]),
      .stable_out (slp_db)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic             wr_en;
      logic             rd_en;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] w1c;
      logic             ring_act;
      logic             thermal_warning_n_act;
      wr_en     = 1'b0;
      rd_en     = 1'b0;
      evt       = '0;
      w1c       = '0;
      ring_act  = 1'b0;
      thermal_warning_n_act = 1'b0;
      state_next = state_reg;

      // pins: only the second stage is read by logic
      state_next.sync1 = {power_button_n_in, sleep_button_n_in, ring_indicate_n_in,
                          thermal_warning_n_in, supply_valid_in, mgmt_bus_clock_in, mgmt_bus_data_in};
      state_next.sync2 = state_reg.sync1;

      // rtc rate tick from the system clock; slightly fast, well inside tolerance
      state_next.tick = 1'b0;
      if (state_reg.div == DIV_W'(RTC_DIV - 1)) begin
         state_next.div  = '0;
         state_next.tick = 1'b1;
      end else begin
         state_next.div = state_reg.div + 1'b1;
      end

      // supply valid: falls at once, rises after a tick saw it and the next confirms
      if (!state_reg.sync2[SY_PG]) begin
         state_next.pg_seen = 1'b0;
         state_next.pg_qual = 1'b0; // R5
      end else if (state_reg.tick) begin
         state_next.pg_seen = 1'b1;
         state_next.pg_qual = state_reg.pg_qual | state_reg.pg_seen; // R4
      end

      // sleep button hold timer; restarts whenever the button level changes
      state_next.ovr_fire = 1'b0;
      if (!slp_db || state_reg.ctrl.pstate == soft_off_state) begin
         state_next.hold     = '0; // R17
         state_next.ovr_done = 1'b0;
      end else if (state_reg.tick && !state_reg.ovr_done) begin
         if (state_reg.hold == OVERRIDE_TICKS - 1'b1) begin
            state_next.ovr_fire = 1'b1; // R1
            state_next.ovr_done = 1'b1;
         end else begin
            state_next.hold = state_reg.hold + 1'b1;
         end
      end

      // events
      state_next.pwr_d   = pwr_db;
      state_next.slp_d   = slp_db;
      state_next.ring_d  = ~state_reg.sync2[SY_RING] & ~state_reg.ctrl.pin_select[SEL_RING];
      state_next.thermal_warning_n_d = ~state_reg.sync2[SY_THERMAL_WARNING_N];
      ring_act           = state_next.ring_d;
      thermal_warning_n_act          = state_next.thermal_warning_n_d;
      evt[EV_POWER] = pwr_db & ~state_reg.pwr_d; // R15
      evt[EV_SLEEP] = slp_db & ~state_reg.slp_d; // R10
      evt[EV_OVR]   = state_reg.ovr_fire; // R2
      evt[EV_RING]  = ring_act & ~state_reg.ring_d; // R9
      evt[EV_THERMAL_WARNING_N] = thermal_warning_n_act & ~state_reg.thermal_warning_n_d;

      // apb: access phase lasts two cycles; effect at the edge that sees pready
      wr_en = psel_in & penable_in & state_reg.ready & pwrite_in;
      rd_en = psel_in & penable_in & ~state_reg.ready & ~pwrite_in;
      state_next.ready  = psel_in & penable_in & ~state_reg.ready;
      state_next.slverr = 1'b0;
      if (psel_in && penable_in && !state_reg.ready) begin
         state_next.slverr = ~(paddr_in inside {CTRL_OFS, STAT_OFS, MASK_OFS, LEVEL_OFS});
      end
      if (rd_en) begin
         unique case (paddr_in)
            CTRL_OFS:  state_next.rdata = state_reg.ctrl;
            STAT_OFS:  state_next.rdata = 32'(state_reg.stat);
            MASK_OFS:  state_next.rdata = 32'(state_reg.mask);
            LEVEL_OFS: state_next.rdata = {18'h0, state_reg.sync2, state_reg.thr, slp_db, pwr_db,
                                           state_reg.pg_qual, state_reg.ctrl.pstate};
            default:   state_next.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_en) begin
         unique case (paddr_in)
            CTRL_OFS: begin
               state_next.ctrl      = pbs_ctrl_s'(pwdata_in);
               state_next.ctrl.zero = '0;
            end
            STAT_OFS: w1c = pwdata_in[EVT_W-1:0];
            MASK_OFS: state_next.mask = pwdata_in[EVT_W-1:0];
            default:  ;
         endcase
      end

      // flags: a new event wins over a clear in the same cycle
      state_next.stat = (state_reg.stat & ~w1c) | evt;
      state_next.irq  = |(state_next.stat & state_next.mask); // R9

      // power state: override beats software, software beats wake
      if (state_reg.ovr_fire) begin
         state_next.ctrl.pstate = soft_off_state; // R2
      end else if (!wr_en || paddr_in != CTRL_OFS) begin
         if (asleep(state_reg.ctrl.pstate) &&
             (evt[EV_POWER] || evt[EV_SLEEP] || (evt[EV_RING] && state_reg.mask[EV_RING]))) begin
            state_next.ctrl.pstate = full_on_state; // R10 R15 R9
         end
      end

      // supply outputs decoded from the state they will show; throttle enable and ratio from the current control word
      state_next.main_n    = main_off(state_next.ctrl.pstate); // R7
      state_next.ram_en    = ~ram_off(state_next.ctrl.pstate); // R8
      state_next.susp_n    = ~state_next.ctrl.suspend_on; // R12
      state_next.plane_rst = ~state_next.pg_qual; // R5
      state_next.thr       = thermal_warning_n_act & state_reg.ctrl.throttle_on_heat_enable; // R11
      state_next.ratio     = state_reg.ctrl.throttle_duty_ratio; // R11

      // pins: general purpose when selected, else button input or open drain
      state_next.pin_o  = '0;
      state_next.pin_oe = '0;
      if (state_next.ctrl.pin_select[SEL_SLEEP]) begin
         state_next.pin_o[0]  = state_next.ctrl.gpio_out[SEL_SLEEP]; // R13
         state_next.pin_oe[0] = state_next.ctrl.gpio_oe[SEL_SLEEP];
      end
      if (state_next.ctrl.pin_select[SEL_RING]) begin
         state_next.pin_o[1]  = state_next.ctrl.gpio_out[SEL_RING]; // R13
         state_next.pin_oe[1] = state_next.ctrl.gpio_oe[SEL_RING];
      end
      if (state_next.ctrl.pin_select[SEL_MCLK]) begin
         state_next.pin_o[2]  = state_next.ctrl.gpio_out[SEL_MCLK]; // R14
         state_next.pin_oe[2] = state_next.ctrl.gpio_oe[SEL_MCLK];
      end else begin
         state_next.pin_oe[2] = mgmt_clock_low_in; // R14
      end
      if (state_next.ctrl.pin_select[SEL_MDATA]) begin
         state_next.pin_o[3]  = state_next.ctrl.gpio_out[SEL_MDATA]; // R14
         state_next.pin_oe[3] = state_next.ctrl.gpio_oe[SEL_MDATA];
      end else begin
         state_next.pin_oe[3] = mgmt_data_low_in; // R14
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_reg           <= '0;
         state_reg.ctrl      <= pbs_ctrl_s'(CTRL_RESET);
         state_reg.sync1     <= SYNC_RESET;
         state_reg.sync2     <= SYNC_RESET;
         state_reg.stat      <= STAT_RESET;
         state_reg.mask      <= MASK_RESET;
         state_reg.main_n    <= 1'b0; // R16
         state_reg.ram_en    <= 1'b1; // R16
         state_reg.susp_n    <= 1'b1; // R16
         state_reg.plane_rst <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign prdata_out               = state_reg.rdata;
   assign pready_out               = state_reg.ready;
   assign pslverr_out              = state_reg.slverr;
   assign irq_out                  = state_reg.irq;
   assign main_supply_enable_n_out = state_reg.main_n;
   assign ram_supply_enable_out    = state_reg.ram_en;
   assign suspend_n_out            = state_reg.susp_n;
   assign plane_reset_out          = state_reg.plane_rst;
   assign throttle_active_out      = state_reg.thr;
   assign throttle_duty_ratio_out  = state_reg.ratio;
   assign sleep_button_n_out       = state_reg.pin_o[0];
   assign sleep_button_n_oe_out    = state_reg.pin_oe[0];
   assign ring_indicate_n_out      = state_reg.pin_o[1];
   assign ring_indicate_n_oe_out   = state_reg.pin_oe[1];
   assign mgmt_bus_clock_out       = state_reg.pin_o[2];
   assign mgmt_bus_clock_oe_out    = state_reg.pin_oe[2];
   assign mgmt_bus_data_out        = state_reg.pin_o[3];
   assign mgmt_bus_data_oe_out     = state_reg.pin_oe[3];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   main_enable_map_a: assert property (main_supply_enable_n_out == main_off(state_reg.ctrl.pstate)) // R7
      else $error("main supply enable does not match power state");
   ram_enable_map_a: assert property (ram_supply_enable_out == !ram_off(state_reg.ctrl.pstate)) // R8
      else $error("ram supply enable does not match power state");
   override_effect_a: assert property (state_reg.ovr_fire |-> ##1 // R2
      state_reg.stat[EV_OVR] && main_supply_enable_n_out)
      else $error("override did not set flag and release main supply");
   override_hold_a: assert property (state_reg.ovr_fire |-> // R1
      $past(state_reg.hold) == OVERRIDE_TICKS - 1'b1 && $past(slp_db))
      else $error("override fired before the full hold time");
   plane_reset_a: assert property (!state_reg.sync2[SY_PG] |-> ##1 plane_reset_out) // R5
      else $error("main plane not held in reset while supply invalid");
   pg_filter_a: assert property ($fell(plane_reset_out) |-> $past(state_reg.tick)) // R4
      else $error("supply valid qualified without an rtc tick");
   sleep_flag_a: assert property ($rose(slp_db) |=> state_reg.stat[EV_SLEEP]) // R10
      else $error("sleep button flag not set");
   power_flag_a: assert property ($rose(pwr_db) |=> state_reg.stat[EV_POWER]) // R15
      else $error("power button flag not set");
   ring_flag_a: assert property ($rose(state_reg.ring_d) |=> state_reg.stat[EV_RING]) // R9
      else $error("ring flag not set");
   // judged on the synced pin: the registered level lags a release by one cycle
   throttle_on_a: assert property (!state_reg.sync2[SY_THERMAL_WARNING_N] && state_reg.ctrl.throttle_on_heat_enable // R11
      |=> throttle_active_out && throttle_duty_ratio_out == $past(state_reg.ctrl.throttle_duty_ratio))
      else $error("throttling not applied on thermal warning");
   suspend_follow_a: assert property (suspend_n_out == !state_reg.ctrl.suspend_on) // R12
      else $error("suspend output does not follow control");
   reset_values_a: assert property ($past(rst_in) |-> // R16
      !main_supply_enable_n_out && ram_supply_enable_out && suspend_n_out)
      else $error("supply outputs wrong after reset");
endmodule

// [sim/pbs_board_model.sv]
// board model: buttons, supply valid and pulled-up pins
`timescale 1ns/100ps
module pbs_board_model #(
   parameter int PG_DELAY = 2000
) (
   input  wire logic       clk_in,
   input  wire logic       main_n_in,
   input  wire logic       cut_in,
   input  wire logic [3:0] press_in,
   input  wire logic [3:0] drv_in,
   input  wire logic [3:0] oe_in,
   output logic [3:0]      pin_out,
   output logic            pg_out
);
   int cnt = 0;
   // ----
   // supply valid stays low until the plane has been good for the delay
   // ----
   always @(posedge clk_in) begin
      if (main_n_in || cut_in) cnt <= 0;
      else if (cnt < PG_DELAY) cnt <= cnt + 1;
   end
   assign pg_out = (cnt >= PG_DELAY);
   // a driven pin wins; otherwise the button or the pull-up sets the level
   assign pin_out = (oe_in & drv_in) | (~oe_in & ~press_in);
endmodule

// [sim/pbs_ctrl_tb_top.sv]
// testbench: apb register tests of the power button and supply block
`timescale 1ns/100ps
module pbs_ctrl_tb_top;
   import pbs_pkg::*;
   localparam int TK = 1220;
   logic        clk_in = '0, rst_in = '1, psel = '0, penable = '0, pwrite = '0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0, rd, prdata;
   logic        err, cut = '0, pwr = '0, slp = '0, ring = '0, thermal_warning_n = '0, cl = '0, dl = '0;
   logic        pready, pslverr, irq, main_n, ram_en, susp_n, prst, thr, pg;
   logic [2:0]  ratio;
   logic [3:0]  drv, oe, pin;
   int          mismatches = 0, n_checks = 0;

   // short counts keep the run brief; tick period stays 1220 clocks
   pbs_ctrl #(.DEBOUNCE_TICKS(10'h003), .OVERRIDE_TICKS(18'h00008)) i_dut (
      .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .power_button_n_in(~pwr),
      .sleep_button_n_in(pin[3]), .sleep_button_n_out(drv[3]), .sleep_button_n_oe_out(oe[3]),
      .ring_indicate_n_in(pin[2]), .ring_indicate_n_out(drv[2]), .ring_indicate_n_oe_out(oe[2]),
      .thermal_warning_n_in(~thermal_warning_n), .supply_valid_in(pg),
      .mgmt_bus_clock_in(pin[1]), .mgmt_bus_clock_out(drv[1]), .mgmt_bus_clock_oe_out(oe[1]),
      .mgmt_bus_data_in(pin[0]), .mgmt_bus_data_out(drv[0]), .mgmt_bus_data_oe_out(oe[0]),
      .mgmt_clock_low_in(cl), .mgmt_data_low_in(dl), .main_supply_enable_n_out(main_n),
      .ram_supply_enable_out(ram_en), .suspend_n_out(susp_n), .plane_reset_out(prst),
      .throttle_active_out(thr), .throttle_duty_ratio_out(ratio));

   // supply delay shortened from the real span
   pbs_board_model #(.PG_DELAY(2000)) i_board (
      .clk_in(clk_in), .main_n_in(main_n), .cut_in(cut), .press_in({slp, ring, 2'h0}),
      .drv_in(drv), .oe_in(oe), .pin_out(pin), .pg_out(pg));

   initial forever #12.5 clk_in = ~clk_in;

   // ----
   // shared tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'h1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) mismatches++;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk_in);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // watchdog: the whole sequence needs about 67000 cycles
   initial begin
      wt(90000);
      mismatches++;
      stop_test;
   end

   // ----
   // test sequence
   // ----
   initial begin
      wt(12);
      rst_in <= 1'h0;
      wt(1);
      chk(main_n, 1'h0);
      chk(ram_en, 1'h1);
      chk(susp_n, 1'h1);
      chk(prst, 1'h1);
      // supply valid delay plus up to two rtc ticks of qualification
      wt(2000 + 3 * TK);
      chk(prst, 1'h0);
      // every power state against both supply enables
      for (int s = 0; s < 7; s++) begin
         apb(1'h1, CTRL_OFS, s);
         wt(2);
         chk(main_n, s > 3);
         chk(ram_en, s < 5);
      end
      apb(1'h0, CTRL_OFS, 32'h0);
      chk(rd, 32'h6);
      chk(prst, 1'h1);
      apb(1'h1, CTRL_OFS, 32'h0000_000b);
      wt(2);
      chk(susp_n, 1'h0);
      // power button wakes suspend-to-ram, seen only after the filter
      apb(1'h1, CTRL_OFS, 32'h4);
      pwr <= 1'h1;
      wt(TK);
      apb(1'h0, STAT_OFS, 32'h0);
      chk(rd[0], 1'h0);
      wt(4 * TK);
      apb(1'h0, STAT_OFS, 32'h0);
      chk(rd[0], 1'h1);
      apb(1'h0, LEVEL_OFS, 32'h0);
      chk(rd[2:0], 3'h0);
      chk(main_n, 1'h0);
      pwr <= 1'h0;
      wt(5 * TK);
      // ring raises an unmasked interrupt; clear by writing one
      apb(1'h1, STAT_OFS, 32'h1f);
      apb(1'h1, MASK_OFS, 32'h08);
      ring <= 1'h1;
      wt(5 * TK);
      chk(irq, 1'h1);
      ring <= 1'h0;
      wt(5 * TK);
      apb(1'h1, STAT_OFS, 32'h08);
      wt(2);
      chk(irq, 1'h0);
      // thermal warning with throttling enabled at ratio 5
      apb(1'h1, CTRL_OFS, 32'h0000_00b0);
      thermal_warning_n <= 1'h1;
      wt(5 * TK);
      chk(thr, 1'h1);
      chk(ratio, 3'h5);
      thermal_warning_n <= 1'h0;
      wt(5 * TK);
      chk(thr, 1'h0);
      // long sleep press: flag first, override only after the hold count
      slp <= 1'h1;
      wt(5 * TK);
      apb(1'h0, STAT_OFS, 32'h0);
      chk(rd[1], 1'h1);
      chk(main_n, 1'h0);
      wt(10 * TK);
      chk(main_n, 1'h1);
      apb(1'h0, STAT_OFS, 32'h0);
      chk(rd[2], 1'h1);
      chk(prst, 1'h1);
      slp <= 1'h0;
      wt(5 * TK);
      // sleep pin and bus clock driven low, ring pin driven high as gpio; data stays open drain
      apb(1'h1, CTRL_OFS, 32'h0007_2700);
      dl <= 1'h1;
      wt(3);
      chk(oe[3], 1'h1);
      chk(pin[3], 1'h0);
      chk({oe[1], drv[1]}, 2'h2);
      chk({oe[2], drv[2]}, 2'h3);
      chk(pin[2], 1'h1);
      chk({oe[0], drv[0]}, 2'h2);
      dl <= 1'h0;
      wt(3);
      chk(oe[0], 1'h0);
      apb(1'h0, 8'h10, 32'h0);
      chk(err, 1'h1); // unmapped offset is refused
      chk(rd, 32'h0);
      stop_test;
   end
endmodule
